/* hw/mpm_pkg.sv */
// Package of constants and types for the motor protection monitor
// Functional notes
// - Stall fault: peak current over level, enabled
// - Stall fault delay 0.1 to 100 s
// - Underload fault: current under level, enabled
// - Underload fault delay 0.1 to 99 s
// - Underload alarm: separate level, alarm enable
// - Underload alarm delay timed independently
// - High power fault: power over level, enabled
// - High power alarm: separate level, enabled
// - High power delays 0.1 to 99 s
// - Low power fault: power under level, enabled
// - Low power alarm: separate level, enabled
// - Undervoltage fault: average voltage under level
// - Undervoltage alarm: separate level, default 90
// - Undervoltage delays 0.1 to 99 s, 3.0
// - Overvoltage fault: average voltage over level
// - Overvoltage alarm: separate level, enabled
// - Overvoltage delays 0.1 to 99 s, 3.0
// - Voltage imbalance fault over level, enabled
// - Voltage imbalance alarm; delays default 3.0
// - Current imbalance fault over level, enabled
// - Current imbalance fault delay, default 3.0
package mpm_pkg;
	// Clock rate and time base
	localparam int CLK_HZ = 10000000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam logic [20:0] TICK_LAST = 21'(TICK_CYC - 1);
	// Delay settings are in tenths of a second
	localparam logic [9:0] DLY_MIN = 10'h001;
	localparam logic [9:0] DLY_MAX_100S = 10'h3e8;
	localparam logic [9:0] DLY_MAX_99S = 10'h3de;
	// Number of detectors
	localparam int NDET = 17;
	// Detector indices
	localparam int D_STALL_F = 0;
	localparam int D_UL_F = 1;
	localparam int D_UL_A = 2;
	localparam int D_HP_F = 3;
	localparam int D_HP_A = 4;
	localparam int D_LP_F = 5;
	localparam int D_LP_A = 6;
	localparam int D_UV_F = 7;
	localparam int D_UV_A = 8;
	localparam int D_OV_F = 9;
	localparam int D_OV_A = 10;
	localparam int D_VI_F = 11;
	localparam int D_VI_A = 12;
	localparam int D_CI_F = 13;
	// Spare slots kept disabled
	localparam int D_SPARE0 = 14;
	// Register offsets (word address on the plain port)
	localparam logic [7:0] A_LVL_BASE = 8'h00;
	localparam logic [7:0] A_DLY_BASE = 8'h20;
	localparam logic [7:0] A_MOT_FEN = 8'h40;
	localparam logic [7:0] A_MOT_AEN = 8'h41;
	localparam logic [7:0] A_STR_FEN = 8'h42;
	localparam logic [7:0] A_STR_AEN = 8'h43;
	localparam logic [7:0] A_STATUS = 8'h44;
	// Enable bit positions, motor set
	localparam int MB_STALL = 0;
	localparam int MB_UL = 1;
	localparam int MB_HP = 2;
	localparam int MB_LP = 3;
	localparam int MB_CI = 4;
	// Enable bit positions, starter set
	localparam int SB_UV = 0;
	localparam int SB_OV = 1;
	localparam int SB_VI = 2;
	// Level reset values
	localparam logic [15:0] RST_STALL = 16'h0258;
	localparam logic [15:0] RST_UL = 16'h0000;
	localparam logic [15:0] RST_PWR = 16'h0000;
	localparam logic [15:0] RST_UV = 16'h005a;
	localparam logic [15:0] RST_OV = 16'h006e;
	localparam logic [15:0] RST_IMB = 16'h000f;
	// Delay reset values in tenths
	localparam logic [9:0] RST_D_SHORT = 10'h001;
	localparam logic [9:0] RST_D_LONG = 10'h01e;
	// Enable sets reset value
	localparam logic [7:0] RST_EN = 8'h00;
	// Compare direction
	typedef enum logic {MPM_ABOVE, MPM_BELOW} mpm_dir_t;
endpackage : mpm_pkg

/* hw/mpm_qual.sv */
// One qualification timer: a condition must hold for the whole delay
`timescale 1ns/1ps
module mpm_qual (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Time base and condition
	input wire logic i_tick,
	input wire logic i_cond,
	input wire logic i_en,
	input wire logic [9:0] i_delay,
	// Indication
	output logic o_flag
);
	logic [9:0] cnt_q; // Tenths elapsed under violation
	logic flag_q;

	// Count tenths while violated; any break restarts from zero
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !i_cond) begin
			cnt_q <= 10'h000;
		end else if (i_tick && cnt_q != 10'h3ff) begin
			cnt_q <= cnt_q + 10'h001;
		end
	end

	// Raise only when the full delay has passed and the enable is on
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= i_en && i_cond && (cnt_q >= i_delay);
		end
	end

	assign o_flag = flag_q;

	a_flag_needs_cond: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_flag |-> $past(i_cond) && $past(i_en))
		else $error("flag without condition");
	a_break_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_cond |=> cnt_q == 10'h000)
		else $error("timer not restarted");
	a_enable_gates: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_en |=> !o_flag)
		else $error("disabled flag raised");
endmodule : mpm_qual

/* hw/mpm_top.sv */
// Motor protection monitor: levels, delays, enables and detectors
`timescale 1ns/1ps
module mpm_top (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Measurements from the front end
	input wire logic [15:0] i_peak_current,
	input wire logic [15:0] i_phase_current,
	input wire logic [15:0] i_real_power,
	input wire logic [15:0] i_avg_voltage,
	input wire logic [15:0] i_volt_imbalance,
	input wire logic [15:0] i_curr_imbalance,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Indications
	output logic o_stall_fault,
	output logic o_underload_fault,
	output logic o_underload_alarm,
	output logic o_high_power_fault,
	output logic o_high_power_alarm,
	output logic o_low_power_fault,
	output logic o_low_power_alarm,
	output logic o_undervolt_fault,
	output logic o_undervolt_alarm,
	output logic o_overvolt_fault,
	output logic o_overvolt_alarm,
	output logic o_volt_imbal_fault,
	output logic o_volt_imbal_alarm,
	output logic o_curr_imbal_fault
);
	localparam int N = mpm_pkg::NDET;

	// Settings storage
	logic [15:0] lvl_q [N]; // Level per detector
	logic [9:0] dly_q [N]; // Delay per detector in tenths
	logic [7:0] mot_fen_q; // Motor fault enable set
	logic [7:0] mot_aen_q; // Motor alarm enable set
	logic [7:0] str_fen_q; // Starter fault enable set
	logic [7:0] str_aen_q; // Starter alarm enable set
	logic [15:0] rdata_q;
	// Time base
	logic [20:0] tick_cnt_q;
	logic tick_q;
	// Detector wiring
	logic [15:0] meas [N];
	logic [N-1:0] below;
	logic [N-1:0] cond;
	logic [N-1:0] en;
	logic [N-1:0] flag;
	logic [N-1:0] out_q;

	// Reset value of a detector level
	function automatic logic [15:0] lvl_rst(input int k);
		logic [15:0] v;
		v = mpm_pkg::RST_PWR;
		if (k == mpm_pkg::D_STALL_F) begin
			v = mpm_pkg::RST_STALL;
		end else if (k == mpm_pkg::D_UL_F || k == mpm_pkg::D_UL_A) begin
			v = mpm_pkg::RST_UL;
		end else if (k == mpm_pkg::D_UV_F || k == mpm_pkg::D_UV_A) begin
			v = mpm_pkg::RST_UV;
		end else if (k == mpm_pkg::D_OV_F || k == mpm_pkg::D_OV_A) begin
			v = mpm_pkg::RST_OV;
		end else if (k >= mpm_pkg::D_VI_F && k <= mpm_pkg::D_CI_F) begin
			v = mpm_pkg::RST_IMB;
		end
		return v;
	endfunction : lvl_rst

	// Reset value of a detector delay: voltage and imbalance are long
	function automatic logic [9:0] dly_rst(input int k);
		logic [9:0] v;
		v = mpm_pkg::RST_D_SHORT;
		if (k >= mpm_pkg::D_UV_F && k <= mpm_pkg::D_CI_F) begin
			v = mpm_pkg::RST_D_LONG;
		end
		return v;
	endfunction : dly_rst

	// Highest delay allowed for a detector
	function automatic logic [9:0] dly_max(input int k);
		logic [9:0] v;
		v = mpm_pkg::DLY_MAX_99S;
		if (k == mpm_pkg::D_STALL_F) begin
			v = mpm_pkg::DLY_MAX_100S;
		end
		return v;
	endfunction : dly_max

	// Clamp a written delay into its legal range
	function automatic logic [9:0] dly_clamp(input logic [15:0] w, input int k);
		logic [9:0] v;
		v = w[9:0];
		if (w[15:10] != 6'h00 || w[9:0] > dly_max(k)) begin
			v = dly_max(k);
		end else if (w[9:0] < mpm_pkg::DLY_MIN) begin
			v = mpm_pkg::DLY_MIN;
		end
		return v;
	endfunction : dly_clamp

	// Tenth of a second tick; delays count in these units
	// One time base is shared by every timer. A violation can therefore see its
	// first tick anywhere from one cycle to a full tenth after it starts, so a
	// delay is met to within one tenth. This trades precision for one counter.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			tick_cnt_q <= 21'h000000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == mpm_pkg::TICK_LAST) begin
			tick_cnt_q <= 21'h000000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 21'h000001;
			tick_q <= 1'b0;
		end
	end

	// Enable sets written by software
	// Bits above the defined ones are stored and read back but drive nothing
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			mot_fen_q <= mpm_pkg::RST_EN;
			mot_aen_q <= mpm_pkg::RST_EN;
			str_fen_q <= mpm_pkg::RST_EN;
			str_aen_q <= mpm_pkg::RST_EN;
		end else if (i_wr) begin
			if (i_addr == mpm_pkg::A_MOT_FEN) begin
				mot_fen_q <= i_wdata[7:0];
			end else if (i_addr == mpm_pkg::A_MOT_AEN) begin
				mot_aen_q <= i_wdata[7:0];
			end else if (i_addr == mpm_pkg::A_STR_FEN) begin
				str_fen_q <= i_wdata[7:0];
			end else if (i_addr == mpm_pkg::A_STR_AEN) begin
				str_aen_q <= i_wdata[7:0];
			end
		end
	end

	// Register read: data stand one cycle after the strobe only
	// Clearing outside the answer cycle keeps a stale word from looking fresh
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !i_rd) begin
			rdata_q <= 16'h0000;
		end else if (i_addr < mpm_pkg::A_LVL_BASE + 8'(N)) begin
			rdata_q <= lvl_q[i_addr[4:0]];
		end else if (i_addr >= mpm_pkg::A_DLY_BASE
			&& i_addr < mpm_pkg::A_DLY_BASE + 8'(N)) begin
			rdata_q <= {6'h00, dly_q[5'(i_addr - mpm_pkg::A_DLY_BASE)]};
		end else if (i_addr == mpm_pkg::A_MOT_FEN) begin
			rdata_q <= {8'h00, mot_fen_q};
		end else if (i_addr == mpm_pkg::A_MOT_AEN) begin
			rdata_q <= {8'h00, mot_aen_q};
		end else if (i_addr == mpm_pkg::A_STR_FEN) begin
			rdata_q <= {8'h00, str_fen_q};
		end else if (i_addr == mpm_pkg::A_STR_AEN) begin
			rdata_q <= {8'h00, str_aen_q};
		end else if (i_addr == mpm_pkg::A_STATUS) begin
			rdata_q <= out_q[15:0];
		end else begin
			rdata_q <= 16'h0000; // Unmapped reads as zero
		end
	end

	// Enable bit for each slot, taken from its own set
	// Spare slots keep a zero enable, so their indications can never rise,
	// whatever level software leaves in them
	always_comb begin
		en = '0;
		en[mpm_pkg::D_STALL_F] = mot_fen_q[mpm_pkg::MB_STALL];
		en[mpm_pkg::D_UL_F] = mot_fen_q[mpm_pkg::MB_UL];
		en[mpm_pkg::D_UL_A] = mot_aen_q[mpm_pkg::MB_UL];
		en[mpm_pkg::D_HP_F] = mot_fen_q[mpm_pkg::MB_HP];
		en[mpm_pkg::D_HP_A] = mot_aen_q[mpm_pkg::MB_HP];
		en[mpm_pkg::D_LP_F] = mot_fen_q[mpm_pkg::MB_LP];
		en[mpm_pkg::D_LP_A] = mot_aen_q[mpm_pkg::MB_LP];
		en[mpm_pkg::D_UV_F] = str_fen_q[mpm_pkg::SB_UV];
		en[mpm_pkg::D_UV_A] = str_aen_q[mpm_pkg::SB_UV];
		en[mpm_pkg::D_OV_F] = str_fen_q[mpm_pkg::SB_OV];
		en[mpm_pkg::D_OV_A] = str_aen_q[mpm_pkg::SB_OV];
		en[mpm_pkg::D_VI_F] = str_fen_q[mpm_pkg::SB_VI];
		en[mpm_pkg::D_VI_A] = str_aen_q[mpm_pkg::SB_VI];
		en[mpm_pkg::D_CI_F] = mot_fen_q[mpm_pkg::MB_CI];
	end

	// Measurement and direction for each slot
	// Measurements are taken as synchronous; a front end on another clock
	// must retime them before they reach these inputs
	always_comb begin
		for (int k = 0; k < N; k++) begin
			meas[k] = 16'h0000;
			below[k] = 1'b0;
		end
		meas[mpm_pkg::D_STALL_F] = i_peak_current;
		meas[mpm_pkg::D_UL_F] = i_phase_current;
		meas[mpm_pkg::D_UL_A] = i_phase_current;
		below[mpm_pkg::D_UL_F] = 1'b1;
		below[mpm_pkg::D_UL_A] = 1'b1;
		meas[mpm_pkg::D_HP_F] = i_real_power;
		meas[mpm_pkg::D_HP_A] = i_real_power;
		meas[mpm_pkg::D_LP_F] = i_real_power;
		meas[mpm_pkg::D_LP_A] = i_real_power;
		below[mpm_pkg::D_LP_F] = 1'b1;
		below[mpm_pkg::D_LP_A] = 1'b1;
		meas[mpm_pkg::D_UV_F] = i_avg_voltage;
		meas[mpm_pkg::D_UV_A] = i_avg_voltage;
		below[mpm_pkg::D_UV_F] = 1'b1;
		below[mpm_pkg::D_UV_A] = 1'b1;
		meas[mpm_pkg::D_OV_F] = i_avg_voltage;
		meas[mpm_pkg::D_OV_A] = i_avg_voltage;
		meas[mpm_pkg::D_VI_F] = i_volt_imbalance;
		meas[mpm_pkg::D_VI_A] = i_volt_imbalance;
		meas[mpm_pkg::D_CI_F] = i_curr_imbalance;
	end

	// Per-slot settings and detector; each has its own timer
	for (genvar g = 0; g < N; g++) begin : g_det
		// Level and delay written by software, delay clamped to range
		always_ff @(posedge i_clk) begin
			if (i_sys_rst) begin
				lvl_q[g] <= lvl_rst(g);
				dly_q[g] <= dly_rst(g);
			end else if (i_wr && i_addr == mpm_pkg::A_LVL_BASE + 8'(g)) begin
				lvl_q[g] <= i_wdata;
			end else if (i_wr && i_addr == mpm_pkg::A_DLY_BASE + 8'(g)) begin
				dly_q[g] <= dly_clamp(i_wdata, g);
			end
		end

		// Strict compare: over exceeds the level, under drops below it
		assign cond[g] = below[g] ? (meas[g] < lvl_q[g]) : (meas[g] > lvl_q[g]);

		mpm_qual u_qual (
			.i_clk(i_clk),
			.i_sys_rst(i_sys_rst),
			.i_tick(tick_q),
			.i_cond(cond[g]),
			.i_en(en[g]),
			.i_delay(dly_q[g]),
			.o_flag(flag[g])
		);
	end

	// Registered indications
	// The extra stage keeps every indication on a flip-flop, at the cost of
	// one more cycle between the timer and the pin
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			out_q <= '0;
		end else begin
			out_q <= flag;
		end
	end

	assign o_rdata = rdata_q;
	assign o_stall_fault = out_q[mpm_pkg::D_STALL_F];
	assign o_underload_fault = out_q[mpm_pkg::D_UL_F];
	assign o_underload_alarm = out_q[mpm_pkg::D_UL_A];
	assign o_high_power_fault = out_q[mpm_pkg::D_HP_F];
	assign o_high_power_alarm = out_q[mpm_pkg::D_HP_A];
	assign o_low_power_fault = out_q[mpm_pkg::D_LP_F];
	assign o_low_power_alarm = out_q[mpm_pkg::D_LP_A];
	assign o_undervolt_fault = out_q[mpm_pkg::D_UV_F];
	assign o_undervolt_alarm = out_q[mpm_pkg::D_UV_A];
	assign o_overvolt_fault = out_q[mpm_pkg::D_OV_F];
	assign o_overvolt_alarm = out_q[mpm_pkg::D_OV_A];
	assign o_volt_imbal_fault = out_q[mpm_pkg::D_VI_F];
	assign o_volt_imbal_alarm = out_q[mpm_pkg::D_VI_A];
	assign o_curr_imbal_fault = out_q[mpm_pkg::D_CI_F];

	// Checks
	a_stall_gated: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_stall_fault |-> $past(mot_fen_q[0], 2))
		else $error("stall fault while disabled");
	a_stall_dly_range: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		dly_q[0] >= 10'h001 && dly_q[0] <= 10'h3e8)
		else $error("stall delay out of range");
	a_ul_dly_range: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		dly_q[1] <= 10'h3de && dly_q[2] <= 10'h3de)
		else $error("underload delay out of range");
	a_ul_alarm_cond: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_underload_alarm |-> $past(i_phase_current, 2) < $past(lvl_q[2], 2))
		else $error("underload alarm without low current");
	a_hp_fault_cond: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_high_power_fault |-> $past(i_real_power, 2) > $past(lvl_q[3], 2))
		else $error("high power fault without high power");
	a_lp_alarm_cond: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_low_power_alarm |-> $past(i_real_power, 2) < $past(lvl_q[6], 2))
		else $error("low power alarm without low power");
	a_uv_fault_cond: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_undervolt_fault |-> $past(i_avg_voltage, 2) < $past(lvl_q[7], 2))
		else $error("undervolt fault without low voltage");
	a_ov_alarm_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_overvolt_alarm |-> $past(str_aen_q[1], 2))
		else $error("overvolt alarm while disabled");
	a_ci_fault_cond: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_curr_imbal_fault |-> $past(i_curr_imbalance, 2) > $past(lvl_q[13], 2))
		else $error("current imbalance fault without cause");
	a_read_one_cycle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_rd |=> o_rdata == 16'h0000)
		else $error("read data outside its cycle");

	// Named steps reused by the checks below
	sequence s_stall_en_off;
		!mot_fen_q[mpm_pkg::MB_STALL];
	endsequence
	sequence s_mfen_write;
		i_wr && i_addr == mpm_pkg::A_MOT_FEN;
	endsequence
	sequence s_lvl0_write;
		i_wr && i_addr == mpm_pkg::A_LVL_BASE;
	endsequence
	sequence s_dly0_zero_write;
		i_wr && i_addr == mpm_pkg::A_DLY_BASE && i_wdata == 16'h0000;
	endsequence
	sequence s_status_read;
		i_rd && i_addr == mpm_pkg::A_STATUS;
	endsequence

	// A dropped enable takes the indication down two edges later
	a_stall_en_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		s_stall_en_off |-> ##2 !o_stall_fault)
		else $error("stall fault outlived its enable");
	// An enable set write lands at the next edge
	a_mfen_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		s_mfen_write |=> mot_fen_q == $past(i_wdata[7:0]))
		else $error("motor fault enable write lost");
	// Levels are stored as written
	a_lvl_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		s_lvl0_write |=> lvl_q[0] == $past(i_wdata))
		else $error("stall level write lost");
	// A zero delay is raised to the shortest legal one
	a_dly_floor: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		s_dly0_zero_write |=> dly_q[0] == mpm_pkg::DLY_MIN)
		else $error("stall delay below its floor");
	// Status read returns the indications of the strobe cycle
	a_status_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		s_status_read |=> o_rdata[13:0] == $past(out_q[13:0]))
		else $error("status read differs from indications");
	// High power alarm follows its own alarm enable
	a_hp_alarm_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_high_power_alarm |-> $past(mot_aen_q[mpm_pkg::MB_HP], 2))
		else $error("high power alarm while disabled");
endmodule : mpm_top

/* tb/mpm_meas_model.sv */
// Behavioural model of the measurement front end feeding the monitor
`timescale 1ns/1ps
module mpm_meas_model (
	// Clock
	input wire logic i_clk,
	// Load port from the bench: channel select and value
	input wire logic i_load,
	input wire logic [2:0] i_sel,
	input wire logic [15:0] i_val,
	// Measurements
	output logic [15:0] o_peak_current,
	output logic [15:0] o_phase_current,
	output logic [15:0] o_real_power,
	output logic [15:0] o_avg_voltage,
	output logic [15:0] o_volt_imbalance,
	output logic [15:0] o_curr_imbalance
);
	// Values hold between updates, as a real front end refreshes its results
	initial begin
		o_peak_current = 16'h0000;
		o_phase_current = 16'h0064;
		o_real_power = 16'h0000;
		o_avg_voltage = 16'h0064;
		o_volt_imbalance = 16'h0000;
		o_curr_imbalance = 16'h0000;
	end
	// One channel changes per clock, just after the edge
	always @(posedge i_clk) begin
		if (i_load) begin
			case (i_sel)
				3'h0: o_peak_current <= i_val;
				3'h1: o_phase_current <= i_val;
				3'h2: o_real_power <= i_val;
				3'h3: o_avg_voltage <= i_val;
				3'h4: o_volt_imbalance <= i_val;
				default: o_curr_imbalance <= i_val;
			endcase
		end
	end
endmodule : mpm_meas_model

/* tb/motor_protection_monitor_tb_top.sv */
// Self-checking bench for the motor protection monitor
`timescale 1ns/1ps
module motor_protection_monitor_tb_top;
	// Clock, reset and register port
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] o_rdata;
	// Front end load port and measurements
	logic meas_load = 1'b0;
	logic [2:0] meas_sel = 3'h0;
	logic [15:0] meas_val = 16'h0000;
	logic [15:0] peak, phase, power, volt, vimb, cimb;
	// Indications, bit k is detector slot k
	logic [13:0] flags;
	// Expected read data notes
	typedef struct {string name; logic [15:0] exp;} mpm_note_t;
	mpm_note_t notes[$];
	int miscompares = 0;
	int total_checks = 0;
	logic rd_seen = 1'b0;

	always #50 i_clk = ~i_clk;

	mpm_meas_model u_meas (.i_clk(i_clk), .i_load(meas_load), .i_sel(meas_sel),
		.i_val(meas_val), .o_peak_current(peak), .o_phase_current(phase),
		.o_real_power(power), .o_avg_voltage(volt), .o_volt_imbalance(vimb),
		.o_curr_imbalance(cimb));

	mpm_top u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_peak_current(peak),
		.i_phase_current(phase), .i_real_power(power), .i_avg_voltage(volt),
		.i_volt_imbalance(vimb), .i_curr_imbalance(cimb), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_stall_fault(flags[0]), .o_underload_fault(flags[1]),
		.o_underload_alarm(flags[2]), .o_high_power_fault(flags[3]),
		.o_high_power_alarm(flags[4]), .o_low_power_fault(flags[5]),
		.o_low_power_alarm(flags[6]), .o_undervolt_fault(flags[7]),
		.o_undervolt_alarm(flags[8]), .o_overvolt_fault(flags[9]),
		.o_overvolt_alarm(flags[10]), .o_volt_imbal_fault(flags[11]),
		.o_volt_imbal_alarm(flags[12]), .o_curr_imbal_fault(flags[13]));

	// Single comparison point
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d, miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	// Read data stands only in the cycle after the strobe, so compare there
	always @(posedge i_clk) begin : mon
		mpm_note_t n;
		rd_seen <= i_rd;
		if (rd_seen) begin
			n = notes.pop_front();
			check(n.name, o_rdata, n.exp);
		end
	end

	// Bus cycles: each strobe is held until the next bus task or idle releases it
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e, input string name);
		notes.push_back('{name, e});
		i_rd <= 1'b1;
		i_wr <= 1'b0;
		i_addr <= a;
		@(posedge i_clk);
	endtask : rd

	task automatic idle(input int n);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		repeat (n) @(posedge i_clk);
	endtask : idle

	task automatic do_reset();
		i_sys_rst <= 1'b1;
		idle(3);
		i_sys_rst <= 1'b0;
	endtask : do_reset

	task automatic done(input string name);
		idle(2);
		$display("test %s done, checks %0d, miscompares %0d", name, total_checks, miscompares);
	endtask : done

	// Defaults: levels 600, 0, 90, 110, 15; delays 0.1 s or 3.0 s; enables off
	task automatic check_defaults();
		logic [15:0] lv;
		for (int k = 0; k < 14; k++) begin
			case (k)
				0: lv = 16'h0258;
				7, 8: lv = 16'h005a;
				9, 10: lv = 16'h006e;
				11, 12, 13: lv = 16'h000f;
				default: lv = 16'h0000;
			endcase
			rd(8'(k), lv, "level default");
			rd(8'h20 + 8'(k), (k < 7) ? 16'h0001 : 16'h001e, "delay default");
		end
		for (int k = 0; k < 5; k++) rd(8'h40 + 8'(k), 16'h0000, "enable or status");
		done("defaults");
	endtask : check_defaults

	// Watchdog, far beyond the roughly 1,140 cycles the tests need
	initial begin
		repeat (20000) @(posedge i_clk);
		miscompares++;
		final_report();
	end

	initial begin
		logic [15:0] lv[14];
		logic [15:0] v;
		void'($urandom(14672));
		do_reset();
		check_defaults();
		// Levels are stored unclamped; back-to-back writes then reads
		for (int k = 0; k < 14; k++) begin
			lv[k] = 16'($urandom);
			wr(8'(k), lv[k]);
		end
		for (int k = 0; k < 14; k++) rd(8'(k), lv[k], "level rw");
		// Each enable set is its own register
		for (int k = 0; k < 4; k++) wr(8'h40 + 8'(k), 16'h0011 * 16'(k + 1));
		for (int k = 0; k < 4; k++) rd(8'h40 + 8'(k), 16'h0011 * 16'(k + 1), "enable rw");
		done("readback");
		// Delay range: 0.1 s minimum, stall 100 s and others 99 s maximum
		for (int k = 0; k < 14; k++) begin
			wr(8'h20 + 8'(k), 16'hffff);
			rd(8'h20 + 8'(k), (k == 0) ? 16'h03e8 : 16'h03de, "delay max");
			wr(8'h20 + 8'(k), 16'h0000);
			rd(8'h20 + 8'(k), 16'h0001, "delay min");
			v = 16'($urandom_range(990, 1));
			wr(8'h20 + 8'(k), v);
			rd(8'h20 + 8'(k), v, "delay in range");
		end
		wr(8'h20, 16'h03e9);
		rd(8'h20, 16'h03e8, "stall delay above");
		wr(8'h21, 16'h03df);
		rd(8'h21, 16'h03de, "underload delay above");
		done("delays");
		// Unmapped place reads zero and ignores writes
		rd(8'h80, 16'h0000, "unmapped");
		wr(8'h80, 16'habcd);
		rd(8'h80, 16'h0000, "unmapped after write");
		rd(8'h00, lv[0], "level untouched");
		done("unmapped");
		// A reset in mid-run restores every setting
		do_reset();
		check_defaults();
		// The 0.1 s time base is fixed at a million cycles, beyond this run's
		// budget, so detectors are only shown not to fire before the delay
		for (int k = 0; k < 4; k++) wr(8'h40 + 8'(k), 16'h00ff);
		for (int k = 0; k < 14; k++) wr(8'h20 + 8'(k), 16'h0001);
		for (int k = 0; k < 6; k++) begin
			meas_load <= 1'b1;
			meas_sel <= 3'(k);
			meas_val <= 16'($urandom_range(1000, 0));
			@(posedge i_clk);
		end
		meas_load <= 1'b0;
		idle(1);
		v = 16'h0000;
		repeat (900) begin
			@(posedge i_clk);
			v = v | {2'h0, flags};
		end
		check("early indications", v, 16'h0000);
		rd(8'h44, 16'h0000, "status early");
		done("no early fire");
		final_report();
	end
endmodule : motor_protection_monitor_tb_top
